// >>> dsdbi_top.sv
// dsdbi_top: door short detection and door bypass interlock with AXI4-Lite registers
// assumes door and bypass pins are asynchronous; RST_I is the power-on reset
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`default_nettype none

module dsdbi_top
  import dsdbi_pkg::*;
(
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // door contact pins
  input  wire logic              FRONT_CAR_DOOR_HV_INPUT_I,
  input  wire logic              REAR_DOOR_CONTACT_INPUT_I,
  input  wire logic              FRONT_CLOSE_LIMIT_I,
  input  wire logic              REAR_CLOSE_LIMIT_I,
  input  wire logic              FRONT_OPEN_LIMIT_I,
  input  wire logic              REAR_OPEN_LIMIT_I,
  input  wire logic              FRONT_DOOR_OPENING_I,
  input  wire logic              REAR_DOOR_OPENING_I,
  // operating state pins
  input  wire logic              ADVANCE_RELEVEL_RUN_I,
  input  wire logic              INSPECTION_MODE_I,
  input  wire logic              EMERGENCY_ELEC_MODE_I,
  input  wire logic              CAR_MOVING_I,
  // bypass pins
  input  wire logic              BYPASS_LANDING_I,
  input  wire logic              BYPASS_CAR_I,
  input  wire logic              BYPASS_LANDING_CLOSED_I,
  input  wire logic              BYPASS_LANDING_LOCK_I,
  input  wire logic              CAR_DOOR_CLOSED_MON_I,
  // safety board and interlock outputs
  output logic                   LOCK_SHORT_COMMAND_O,
  output logic                   AUX_STOP_OUTPUT_A_O,
  output logic                   AUX_STOP_OUTPUT_B_O,
  output logic                   DOOR_SHORT_FAULT_O,
  output logic                   NORMAL_RUN_OK_O,
  output logic                   AUTO_DOOR_EN_O,
  output logic                   MOTION_PERMIT_O,
  output logic                   BUZZER_O,
  output logic                   FLASH_LIGHT_O,
  // AXI4-Lite slave
  input  wire logic              AXI_AWVALID_I,
  output logic                   AXI_AWREADY_O,
  input  wire logic [ADDR_W-1:0] AXI_AWADDR_I,
  input  wire logic              AXI_WVALID_I,
  output logic                   AXI_WREADY_O,
  input  wire logic [31:0]       AXI_WDATA_I,
  input  wire logic [3:0]        AXI_WSTRB_I,
  output logic                   AXI_BVALID_O,
  input  wire logic              AXI_BREADY_I,
  output logic [1:0]             AXI_BRESP_O,
  input  wire logic              AXI_ARVALID_I,
  output logic                   AXI_ARREADY_O,
  input  wire logic [ADDR_W-1:0] AXI_ARADDR_I,
  output logic                   AXI_RVALID_O,
  input  wire logic              AXI_RREADY_I,
  output logic [31:0]            AXI_RDATA_O,
  output logic [1:0]             AXI_RRESP_O
);

  typedef struct packed {
    logic [NPIN-1:0]   s1;
    logic [NPIN-1:0]   s2;
    logic [CTRL_W-1:0] ctrl;
    dsdbi_ck_type [1:0] ck;
    logic [1:0][CNT_W-1:0] cnt;
    logic [1:0]        healthy;
    logic              fault;
    logic              insp_prev;
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } dsdbi_state_type;

  dsdbi_state_type st_r;
  dsdbi_state_type st_nxt;

  logic [NPIN-1:0] pins;
  logic            det_en;
  logic            insp_rise;
  logic [1:0]      fail;
  logic            bp_any;
  logic            bp_bad;
  logic            motion_ok;

  // contact input and close limit both released for side s
  function automatic logic released(input logic [NPIN-1:0] p, input int s);
    logic contact;
    contact = (s == 0) ? p[P_FCD] : p[P_RDC];
    return !contact && !p[P_CLIM + s];
  endfunction : released

  function automatic logic [31:0] reg_read(input dsdbi_state_type s,
                                           input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    if (a == CTRL_OFS) begin
      v[CTRL_W-1:0] = s.ctrl;
    end else if (a == STATUS_OFS) begin
      v[S_FAULT]           = s.fault;
      v[S_HEALTHY +: 2]    = s.healthy;
      v[S_SHORT]           = (s.ck[0] == CK_SHORT) || (s.ck[1] == CK_SHORT);
      v[S_BP_ANY]          = bp_any;
      v[S_BP_BAD]          = bp_bad;
      v[S_CODE +: 8]       = s.fault ? FAULT_CODE : 8'h00;
    end
    return v;
  endfunction : reg_read

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == CTRL_OFS) || (a == STATUS_OFS);
  endfunction : mapped

  assign pins = {CAR_MOVING_I, CAR_DOOR_CLOSED_MON_I, BYPASS_LANDING_LOCK_I,
                 BYPASS_LANDING_CLOSED_I, BYPASS_CAR_I, BYPASS_LANDING_I,
                 EMERGENCY_ELEC_MODE_I, INSPECTION_MODE_I, ADVANCE_RELEVEL_RUN_I,
                 REAR_DOOR_OPENING_I, FRONT_DOOR_OPENING_I,
                 REAR_OPEN_LIMIT_I, FRONT_OPEN_LIMIT_I,
                 REAR_CLOSE_LIMIT_I, FRONT_CLOSE_LIMIT_I,
                 REAR_DOOR_CONTACT_INPUT_I, FRONT_CAR_DOOR_HV_INPUT_I};

  // derived interlock terms from control bits and synchronised pins
  assign det_en    = st_r.ctrl[C_ADV] || st_r.ctrl[C_RELEV];
  assign insp_rise = st_r.s2[P_INSP] && !st_r.insp_prev;
  assign bp_any    = st_r.s2[P_BPL] || st_r.s2[P_BPC]
                   || st_r.s2[P_BPLC] || st_r.s2[P_BPLK];
  assign bp_bad    = (st_r.s2[P_BPL] && st_r.s2[P_BPC])
                   || (st_r.ctrl[C_MANUAL] && st_r.s2[P_BPLC]
                       && st_r.s2[P_BPLK]);

  always_comb begin
    motion_ok = 1'b1;
    if (bp_any) begin
      motion_ok = (st_r.s2[P_INSP] || st_r.s2[P_EMER]) && !bp_bad;
      if (st_r.s2[P_BPC] && !st_r.s2[P_CMON]) begin
        motion_ok = 1'b0;
      end
    end else if (st_r.fault && !st_r.s2[P_INSP]) begin
      motion_ok = 1'b0;
    end
  end

  always_comb begin
    st_nxt           = st_r;
    fail             = 2'b00;
    st_nxt.s1        = pins;
    st_nxt.s2        = st_r.s1;
    st_nxt.insp_prev = st_r.s2[P_INSP];

    // per-side checks run independently, so both sides may run at once
    for (int s = 0; s < 2; s++) begin
      case (st_r.ck[s])
        CK_IDLE: begin
          if (det_en && st_r.s2[P_OPEN + s] && st_r.s2[P_ADVRUN]) begin
            st_nxt.ck[s]      = CK_OPEN;
            st_nxt.healthy[s] = 1'b0;
          end
        end
        CK_OPEN: begin
          if (!st_r.s2[P_OPEN + s]) begin
            st_nxt.ck[s] = CK_IDLE;
          end else if (st_r.s2[P_OLIM + s]) begin
            if (!released(st_r.s2, s)) begin
              fail[s]      = 1'b1;
              st_nxt.ck[s] = CK_IDLE;
            end else if (!st_r.s2[P_INSP]) begin
              st_nxt.ck[s]  = CK_SHORT;
              st_nxt.cnt[s] = '0;
            end else begin
              st_nxt.ck[s]      = CK_PASS;
              st_nxt.healthy[s] = 1'b1;
            end
          end
        end
        CK_SHORT: begin
          st_nxt.cnt[s] = st_r.cnt[s] + CNT_W'(1);
          if (st_r.cnt[s] == CNT_W'(SETTLE_CYC - 1)) begin
            if (released(st_r.s2, s)) begin
              st_nxt.ck[s]      = CK_PASS;
              st_nxt.healthy[s] = 1'b1;
            end else begin
              fail[s]      = 1'b1;
              st_nxt.ck[s] = CK_IDLE;
            end
          end
        end
        CK_PASS: begin
          if (!st_r.s2[P_OPEN + s]) begin
            st_nxt.ck[s] = CK_IDLE;
          end
        end
        default: begin
          st_nxt.ck[s] = CK_IDLE;
        end
      endcase
      if (!det_en) begin
        st_nxt.ck[s] = CK_IDLE;
      end
    end

    // latched fault: a new failure wins over the inspection clear
    if (fail != 2'b00) begin
      st_nxt.fault = 1'b1;
    end else if (insp_rise) begin
      st_nxt.fault = 1'b0;
    end

    // write channel: address and data taken in either order
    if (AXI_AWVALID_I && AXI_AWREADY_O) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && AXI_WREADY_O) begin
      st_nxt.w_got   = 1'b1;
      st_nxt.w_data  = AXI_WDATA_I;
      st_nxt.w_lane0 = AXI_WSTRB_I[0];
    end
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = mapped(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (st_r.aw_addr == CTRL_OFS && st_r.w_lane0) begin
        st_nxt.ctrl = st_r.w_data[CTRL_W-1:0];
      end
    end
    if (st_r.bvalid && AXI_BREADY_I) begin
      st_nxt.bvalid = 1'b0;
    end

    // read channel
    if (AXI_ARVALID_I && AXI_ARREADY_O) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = reg_read(st_r, AXI_ARADDR_I);
      st_nxt.rresp  = mapped(AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rvalid && AXI_RREADY_I) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r      <= '0;
      st_r.ctrl <= CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign LOCK_SHORT_COMMAND_O = (st_r.ck[0] == CK_SHORT)
                              || (st_r.ck[1] == CK_SHORT);
  assign AUX_STOP_OUTPUT_A_O  = st_r.ctrl[C_ASYNC] && LOCK_SHORT_COMMAND_O;
  assign AUX_STOP_OUTPUT_B_O  = st_r.ctrl[C_ASYNC] && LOCK_SHORT_COMMAND_O;
  assign DOOR_SHORT_FAULT_O   = st_r.fault;
  assign NORMAL_RUN_OK_O      = !st_r.fault && !bp_any;
  assign AUTO_DOOR_EN_O       = !bp_any;
  assign MOTION_PERMIT_O      = motion_ok;
  assign BUZZER_O             = bp_any && st_r.s2[P_MOVE];
  assign FLASH_LIGHT_O        = bp_any && st_r.s2[P_MOVE];
  assign AXI_AWREADY_O        = !st_r.aw_got && !st_r.bvalid;
  assign AXI_WREADY_O         = !st_r.w_got && !st_r.bvalid;
  assign AXI_BVALID_O         = st_r.bvalid;
  assign AXI_BRESP_O          = st_r.bresp;
  assign AXI_ARREADY_O        = !st_r.rvalid;
  assign AXI_RVALID_O         = st_r.rvalid;
  assign AXI_RDATA_O          = st_r.rdata;
  assign AXI_RRESP_O          = st_r.rresp;

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_fail_sets_fault: assert property (
    (fail != 2'b00) |=> DOOR_SHORT_FAULT_O && !NORMAL_RUN_OK_O)
    else $error("door short failure did not latch fault");

  a_fault_holds: assert property (
    DOOR_SHORT_FAULT_O && !insp_rise |=> DOOR_SHORT_FAULT_O)
    else $error("fault dropped without inspection entry");

  a_fault_clears: assert property (
    insp_rise && (fail == 2'b00) |=> !DOOR_SHORT_FAULT_O)
    else $error("inspection entry did not clear fault");

  a_detect_gated: assert property (
    !det_en |=> (st_r.ck[0] == CK_IDLE) && (st_r.ck[1] == CK_IDLE))
    else $error("detection ran while both enables off");

  a_short_hold: assert property (
    $rose(LOCK_SHORT_COMMAND_O) |-> !$past(st_r.s2[P_INSP])
      ##0 LOCK_SHORT_COMMAND_O [*8])
    else $error("lock short in inspection or too short");

  a_front_release: assert property (
    (st_r.ck[0] == CK_OPEN) && st_r.s2[P_OPEN] && st_r.s2[P_OLIM]
      && st_r.s2[P_FCD] |=> DOOR_SHORT_FAULT_O)
    else $error("front contact held but no fault");

  a_rear_release: assert property (
    (st_r.ck[1] == CK_OPEN) && st_r.s2[P_OPEN+1] && st_r.s2[P_OLIM+1]
      && st_r.s2[P_CLIM+1] |=> DOOR_SHORT_FAULT_O)
    else $error("rear close limit held but no fault");

  a_aux_follow: assert property (
    st_r.ctrl[C_ASYNC] && LOCK_SHORT_COMMAND_O |-> AUX_STOP_OUTPUT_A_O
      && AUX_STOP_OUTPUT_B_O)
    else $error("aux stop outputs not driven");

  a_bypass_normal: assert property (
    bp_any |-> !NORMAL_RUN_OK_O && !AUTO_DOOR_EN_O)
    else $error("normal operation under bypass");

  a_bypass_both: assert property (
    st_r.s2[P_BPL] && st_r.s2[P_BPC] |-> !MOTION_PERMIT_O)
    else $error("motion with landing and car bypass");

  a_manual_pair: assert property (
    st_r.ctrl[C_MANUAL] && st_r.s2[P_BPLC] && st_r.s2[P_BPLK]
      |-> !MOTION_PERMIT_O)
    else $error("motion with closed and lock bypass");

  a_car_monitor: assert property (
    st_r.s2[P_BPC] && !st_r.s2[P_CMON] |-> !MOTION_PERMIT_O)
    else $error("car bypass motion without monitor");

  a_bypass_mode: assert property (
    bp_any && MOTION_PERMIT_O |-> st_r.s2[P_INSP] || st_r.s2[P_EMER])
    else $error("bypass motion outside allowed modes");

  a_bypass_warn: assert property (
    bp_any && st_r.s2[P_MOVE] |-> BUZZER_O && FLASH_LIGHT_O)
    else $error("no warning during bypass motion");

  a_pass_healthy: assert property (
    (st_r.ck[0] != CK_PASS) ##1 (st_r.ck[0] == CK_PASS) |-> st_r.healthy[0])
    else $error("pass without healthy mark");

  c_front_pass: cover property ((st_r.ck[0] == CK_SHORT) ##1 (st_r.ck[0] == CK_PASS));
  c_fault_raise: cover property ($rose(DOOR_SHORT_FAULT_O));
  c_both_short: cover property ((st_r.ck[0] == CK_SHORT) && (st_r.ck[1] == CK_SHORT));
  c_bypass_run: cover property (bp_any && MOTION_PERMIT_O && BUZZER_O);

endmodule : dsdbi_top

`default_nettype wire

// >>> dsdbi_pkg.sv
// dsdbi_pkg: constants and types of the door short detect and bypass interlock
// assumes a 20 MHz clock and an AXI4-Lite register bus with 32-bit data
`default_nettype none

package dsdbi_pkg;

  // clock and timing
  localparam int CLK_NS        = 50;
  localparam int SETTLE_NS     = 100000;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W         = 12;

  // register map
  localparam int ADDR_W        = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam int CTRL_W        = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;

  // control fields
  localparam int C_ADV         = 0;
  localparam int C_RELEV       = 1;
  localparam int C_ASYNC       = 2;
  localparam int C_MANUAL      = 3;

  // status fields
  localparam int S_FAULT       = 0;
  localparam int S_HEALTHY     = 1;
  localparam int S_SHORT       = 3;
  localparam int S_BP_ANY      = 4;
  localparam int S_BP_BAD      = 5;
  localparam int S_CODE        = 8;
  localparam logic [7:0] FAULT_CODE = 8'h5C;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // synchronised pin vector layout
  localparam int P_FCD   = 0;
  localparam int P_RDC   = 1;
  localparam int P_CLIM  = 2;
  localparam int P_OLIM  = 4;
  localparam int P_OPEN  = 6;
  localparam int P_ADVRUN = 8;
  localparam int P_INSP  = 9;
  localparam int P_EMER  = 10;
  localparam int P_BPL   = 11;
  localparam int P_BPC   = 12;
  localparam int P_BPLC  = 13;
  localparam int P_BPLK  = 14;
  localparam int P_CMON  = 15;
  localparam int P_MOVE  = 16;
  localparam int NPIN    = 17;

  typedef enum logic [1:0] {CK_IDLE, CK_OPEN, CK_SHORT, CK_PASS} dsdbi_ck_type;

endpackage : dsdbi_pkg

`default_nettype wire

// >>> dsdbi_door_model.sv
// dsdbi_door_model: contact, closed-limit and open-limit pins of both door sides
// assumes the bench commands each side; side 0 front, side 1 rear
`default_nettype none
module dsdbi_door_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // door commands
  input  wire logic [1:0] open_i,
  input  wire logic [1:0] stuck_i,
  input  wire logic [7:0] dly_i,
  // door pins
  output var  logic [1:0] contact_o,
  output var  logic [1:0] close_o,
  output var  logic [1:0] olim_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [2];
  // contact and limit release after dly_i, fully open after twice that
  // a stuck side keeps both its contact and its close limit made
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt       <= '{0, 0};
      contact_o <= 2'h3;
      close_o   <= 2'h3;
      olim_o    <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (!open_i[s]) begin
          cnt[s]       <= 0;
          contact_o[s] <= 1'h1;
          close_o[s]   <= 1'h1;
          olim_o[s]    <= 1'h0;
        end else begin
          if (cnt[s] < 2 * dly_i) cnt[s] <= cnt[s] + 1;
          if (cnt[s] == dly_i) contact_o[s] <= stuck_i[s];
          if (cnt[s] == dly_i) close_o[s] <= stuck_i[s];
          if (cnt[s] == 2 * dly_i) olim_o[s] <= 1'h1;
        end
      end
    end
  end
endmodule : dsdbi_door_model
`default_nettype wire

// >>> door_short_detect_bypass_interlock_bench.sv
// door_short_detect_bypass_interlock_bench: self-checking bench of dsdbi_top
// assumes dsdbi_door_model drives the door pins; the bench drives mode, bypass and AXI pins
`default_nettype none
module door_short_detect_bypass_interlock_bench;
  import dsdbi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              CLK_I, RST_I, adv, insp, emer, mov, bpl, bpc, bplc, bplk, mon;
  logic [1:0]        d_open, d_stuck, cont, clim, olim, bresp, rresp;
  logic [7:0]        d_dly;
  logic              lsh, aux_a, aux_b, fault, run_ok, door_en, permit, buzz, flash;
  logic              awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [ADDR_W-1:0] awa, ara;
  logic [3:0]        wstrb;
  logic [31:0]       wd, rd, r;
  int                num_errors, num_checks, seed, n;

  dsdbi_door_model door_u (.clk_i(CLK_I), .rst_i(RST_I), .open_i(d_open), .stuck_i(d_stuck),
    .dly_i(d_dly), .contact_o(cont), .close_o(clim), .olim_o(olim));
  dsdbi_top dut_u (.CLK_I(CLK_I), .RST_I(RST_I), .FRONT_CAR_DOOR_HV_INPUT_I(cont[0]),
    .REAR_DOOR_CONTACT_INPUT_I(cont[1]), .FRONT_CLOSE_LIMIT_I(clim[0]),
    .REAR_CLOSE_LIMIT_I(clim[1]), .FRONT_OPEN_LIMIT_I(olim[0]), .REAR_OPEN_LIMIT_I(olim[1]),
    .FRONT_DOOR_OPENING_I(d_open[0]), .REAR_DOOR_OPENING_I(d_open[1]),
    .ADVANCE_RELEVEL_RUN_I(adv), .INSPECTION_MODE_I(insp), .EMERGENCY_ELEC_MODE_I(emer),
    .CAR_MOVING_I(mov), .BYPASS_LANDING_I(bpl), .BYPASS_CAR_I(bpc),
    .BYPASS_LANDING_CLOSED_I(bplc), .BYPASS_LANDING_LOCK_I(bplk), .CAR_DOOR_CLOSED_MON_I(mon),
    .LOCK_SHORT_COMMAND_O(lsh), .AUX_STOP_OUTPUT_A_O(aux_a), .AUX_STOP_OUTPUT_B_O(aux_b),
    .DOOR_SHORT_FAULT_O(fault), .NORMAL_RUN_OK_O(run_ok), .AUTO_DOOR_EN_O(door_en),
    .MOTION_PERMIT_O(permit), .BUZZER_O(buzz), .FLASH_LIGHT_O(flash),
    .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_AWADDR_I(awa), .AXI_WVALID_I(wv),
    .AXI_WREADY_O(wr), .AXI_WDATA_I(wd), .AXI_WSTRB_I(wstrb), .AXI_BVALID_O(bv),
    .AXI_BREADY_I(br), .AXI_BRESP_O(bresp), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr),
    .AXI_ARADDR_I(ara), .AXI_RVALID_O(rv), .AXI_RREADY_I(rr), .AXI_RDATA_O(rd),
    .AXI_RRESP_O(rresp));

  initial begin
    CLK_I = 1'h0;
    forever #25 CLK_I = ~CLK_I;
  end

  task automatic results;
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic hang(input string nm);
    num_errors++;
    $display("[FAIL] %s expected answer seen none", nm);
    results();
  endtask : hang

  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, ad, wdn;
    logic [1:0] rs;
    int k;
    ad = 1'h0;
    wdn = 1'h0;
    k = 0;
    @(posedge CLK_I);
    awa <= a;
    wd <= d;
    wstrb <= 4'hF;
    awv <= 1'h1;
    wv <= 1'h1;
    while (!(ad && wdn)) begin
      @(negedge CLK_I);
      ah = (awv & awr) === 1'h1;
      wh = (wv & wr) === 1'h1;
      @(posedge CLK_I);
      if (ah) awv <= 1'h0;
      if (wh) wv <= 1'h0;
      ad = ad | ah;
      wdn = wdn | wh;
      if (++k > 50) hang("write take");
    end
    br <= 1'h1;
    do begin
      @(negedge CLK_I);
      ah = bv;
      rs = bresp;
      @(posedge CLK_I);
      if (++k > 100) hang("write response");
    end while (ah !== 1'h1);
    br <= 1'h0;
    chk("bresp", er, rs);
  endtask : axi_wr

  task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    logic h;
    logic [31:0] d;
    logic [1:0] rs;
    int k;
    k = 0;
    @(posedge CLK_I);
    ara <= a;
    arv <= 1'h1;
    do begin
      @(negedge CLK_I);
      h = arr;
      @(posedge CLK_I);
      if (++k > 50) hang("read take");
    end while (h !== 1'h1);
    arv <= 1'h0;
    rr <= 1'h1;
    do begin
      @(negedge CLK_I);
      h = rv;
      d = rd;
      rs = rresp;
      @(posedge CLK_I);
      if (++k > 100) hang("read data");
    end while (h !== 1'h1);
    rr <= 1'h0;
    chk("rresp", er, rs);
    chk("rdata", e, d & m);
  endtask : axi_rd

  task automatic doors(input logic [1:0] s, input logic [1:0] st, input logic [7:0] d);
    @(posedge CLK_I);
    d_open <= s;
    d_stuck <= st;
    d_dly <= d;
    adv <= |s;
    repeat (10) @(posedge CLK_I);
  endtask : doors

  // 0: lock short up, 1: lock short down, 2: fault up; n counts the cycles
  task automatic wait_on(input int w, input int lim);
    n = 0;
    while ((w == 0 ? lsh : (w == 1 ? !lsh : fault)) !== 1'h1) begin
      @(negedge CLK_I);
      if (++n > lim) hang("door check");
    end
  endtask : wait_on

  // expected {run ok, auto door, motion permit, buzzer, flash} with no fault
  function automatic logic [4:0] model(input logic man);
    logic any, bad, p;
    any = bpl | bpc | bplc | bplk;
    bad = (bpl & bpc) | (man & bplc & bplk);
    p = any ? ((insp | emer) & !bad & (!bpc | mon)) : 1'h1;
    return {!any, !any, p, any & mov, any & mov};
  endfunction : model

  initial begin
    {d_open, d_stuck, adv, insp, emer, mov, bpl, bpc, bplc, bplk, mon} = '0;
    {awv, wv, br, arv, rr, awa, ara, wstrb, wd} = '0;
    d_dly = 8'h03;
    num_errors = 0;
    num_checks = 0;
    seed = 32'h41B04383;
    RST_I = 1'h1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'h0;
    @(negedge CLK_I);
    chk("reset outputs", 32'h1C, {lsh, fault, run_ok, door_en, permit, buzz, flash});
    axi_rd(CTRL_OFS, 32'hF, 32'h0, RESP_OKAY);
    axi_rd(STATUS_OFS, 32'hFFFF, 32'h0, RESP_OKAY);
    axi_rd(4'h8, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    axi_wr(4'hC, 32'hF, RESP_SLVERR);
    doors(2'h1, 2'h1, 8'h03);
    repeat (100) @(posedge CLK_I);
    chk("detect off", 32'h0, {lsh, fault});
    doors(2'h0, 2'h0, 8'h03);
    axi_wr(CTRL_OFS, 32'h5, RESP_OKAY);
    doors(2'h1, 2'h0, 8'h03);
    wait_on(0, 300);
    chk("aux stop", 32'h3, {aux_a, aux_b});
    wait_on(1, SETTLE_CYC + 50);
    chk("lock short cycles", SETTLE_CYC, n);
    doors(2'h0, 2'h0, 8'h03);
    axi_rd(STATUS_OFS, 32'hFFFF, 32'h2, RESP_OKAY);
    axi_wr(CTRL_OFS, 32'h2, RESP_OKAY);
    doors(2'h3, 2'h0, 8'h28);
    wait_on(0, 300);
    chk("aux stop sync", 32'h0, {aux_a, aux_b});
    wait_on(1, SETTLE_CYC + 50);
    doors(2'h0, 2'h0, 8'h03);
    axi_rd(STATUS_OFS, 32'hFFFF, 32'h6, RESP_OKAY);
    axi_wr(CTRL_OFS, 32'h5, RESP_OKAY);
    doors(2'h2, 2'h2, 8'h05);
    wait_on(2, 300);
    chk("fault outputs", 32'h8, {fault, run_ok, lsh, permit});
    axi_rd(STATUS_OFS, 32'hFF01, 32'h5C01, RESP_OKAY);
    doors(2'h0, 2'h0, 8'h03);
    // power-off clears the latched fault
    RST_I <= 1'h1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'h0;
    @(negedge CLK_I);
    chk("fault after power off", 32'h1, {fault, run_ok});
    axi_wr(CTRL_OFS, 32'h5, RESP_OKAY);
    doors(2'h1, 2'h1, 8'h03);
    wait_on(2, 300);
    chk("front stuck fault", 32'h1, fault);
    doors(2'h0, 2'h0, 8'h03);
    doors(2'h3, 2'h0, 8'h03);
    wait_on(0, 300);
    wait_on(1, SETTLE_CYC + 50);
    chk("fault held", 32'h1, fault);
    doors(2'h0, 2'h0, 8'h03);
    insp <= 1'h1;
    repeat (4) @(posedge CLK_I);
    chk("fault cleared", 32'h1, {fault, run_ok});
    doors(2'h1, 2'h0, 8'h03);
    repeat (40) @(posedge CLK_I);
    chk("lock short in inspection", 32'h0, lsh);
    doors(2'h0, 2'h0, 8'h03);
    axi_rd(STATUS_OFS, 32'hB, 32'h2, RESP_OKAY);
    for (int m = 0; m < 2; m++) begin
      axi_wr(CTRL_OFS, {28'h0, m[0], 3'h0}, RESP_OKAY);
      repeat (40) begin
        @(posedge CLK_I);
        r = $random(seed);
        {bpl, bpc, bplc, bplk, mon, insp, emer, mov} <= r[7:0];
        repeat (4) @(posedge CLK_I);
        @(negedge CLK_I);
        chk("interlocks", model(m[0]), {run_ok, door_en, permit, buzz, flash});
      end
    end
    results();
  end
endmodule : door_short_detect_bypass_interlock_bench
`default_nettype wire
